// ### inc/simd_defs.svh
`ifndef SIMD_DEFS_SVH
`define SIMD_DEFS_SVH

`define VREG_COUNT      8
`define VREG_IDX_W      3
`define VREG_W          64
`define HALF_W          32
`define SAT_SB_MAX      8'h7f
`define SAT_SB_MIN      8'h80
`define SAT_SW_MAX      16'h7fff
`define SAT_SW_MIN      16'h8000
`define SAT_UB_MAX      8'hff
`define SAT_UB_MIN      8'h00
`define SAT_UW_MAX      16'hffff
`define SAT_UW_MIN      16'h0000

`endif

// ### inc/simd_pkg.sv
package simd_pkg;
    typedef enum logic [1:0] {LANE_BYTE, LANE_WORD, LANE_DWORD, LANE_QWORD} lane_size_e;
    typedef enum logic [1:0] {ARITH_WRAP, ARITH_SSAT, ARITH_USAT} arith_mode_e;
    typedef enum logic [2:0] {
        OP_ADD, OP_SUB, OP_AND, OP_ANDN, OP_OR, OP_XOR, OP_MOV
    } alu_op_e;
    typedef struct packed {
        logic        valid;
        alu_op_e     op;
        lane_size_e  size;
        arith_mode_e mode;
        logic [2:0]  src_a;
        logic [2:0]  src_b;
        logic [2:0]  dst;
    } alu_cmd_s;
    typedef struct packed {
        logic        valid;
        logic        half;      // 1: 32-bit path, low half, upper zeroed; only the vector view uses it, fp writes ignore it
        logic [2:0]  idx;
        logic [63:0] data;
    } reg_write_s;
endpackage

// ### verilog/simd_datapath.sv
`include "simd_defs.svh"

module simd_datapath import simd_pkg::*; (
    input  wire logic                   sys_clk,     // core clock
    input  wire logic                   sys_rst,     // sync reset, active high
    input  wire alu_cmd_s               alu_cmd,     // packed operation request
    input  wire reg_write_s             vec_wr,      // vector view write (load/move)
    input  wire reg_write_s             fp_wr,       // floating-point stack view write
    input  wire logic [2:0]             vec_rd_idx,  // vector view read index
    input  wire logic                   vec_rd_half, // 32-bit read path select
    input  wire logic [2:0]             fp_rd_idx,   // fp stack view read index
    output logic      [63:0]            vec_rd_data, // vector read data
    output logic      [63:0]            fp_rd_data,  // fp stack read data
    output logic      [63:0]            alu_result,  // last operation result
    output logic                        alu_done     // result valid pulse
);
    // one shared array: both views index the same storage
    logic [`VREG_W-1:0] stack_mem [`VREG_COUNT];
    logic [63:0]        lane_out;                    // lane results of the current request
    logic [63:0]        result_reg;
    logic [63:0]        result_next;
    logic               done_reg;
    logic               done_next;

    // add/sub per lane width: wrapping, signed saturating or unsigned saturating
    function automatic logic [15:0] lane_op(input logic [15:0] a, input logic [15:0] b, input logic sub,
                                             input logic is_byte, input arith_mode_e mode);
        logic [16:0] ext_a;
        logic [16:0] ext_b;
        logic [16:0] sum;
        logic        s_ovf;
        logic        u_ovf;
        ext_a = '0;
        ext_b = '0;
        if (is_byte) begin
            ext_a = (mode == ARITH_SSAT) ? {{9{a[7]}}, a[7:0]} : {9'h000, a[7:0]};
            ext_b = (mode == ARITH_SSAT) ? {{9{b[7]}}, b[7:0]} : {9'h000, b[7:0]};
        end else begin
            ext_a = (mode == ARITH_SSAT) ? {a[15], a} : {1'b0, a};
            ext_b = (mode == ARITH_SSAT) ? {b[15], b} : {1'b0, b};
        end
        sum = sub ? ext_a - ext_b : ext_a + ext_b;
        if (is_byte) begin
            s_ovf = (sum[16:7] != {10{sum[7]}});
            u_ovf = (sum[16:8] != 9'h000);
            case (mode)
                ARITH_SSAT: lane_op = {8'h00, s_ovf ? (sum[16] ? `SAT_SB_MIN : `SAT_SB_MAX) : sum[7:0]};
                ARITH_USAT: lane_op = {8'h00, u_ovf ? (sub ? `SAT_UB_MIN : `SAT_UB_MAX) : sum[7:0]};
                default:    lane_op = {8'h00, sum[7:0]};
            endcase
        end else begin
            s_ovf = (sum[16] != sum[15]);
            u_ovf = sum[16];
            case (mode)
                ARITH_SSAT: lane_op = s_ovf ? (sum[16] ? `SAT_SW_MIN : `SAT_SW_MAX) : sum[15:0];
                ARITH_USAT: lane_op = u_ovf ? (sub ? `SAT_UW_MIN : `SAT_UW_MAX) : sum[15:0];
                default:    lane_op = sum[15:0];
            endcase
        end
    endfunction

    // operands come straight from storage, so a write one edge earlier is already seen
    logic [63:0] opa;
    logic [63:0] opb;
    assign opa = stack_mem[alu_cmd.src_a];
    assign opb = stack_mem[alu_cmd.src_b];
    // subtract shares the adder; the spare lane bit doubles as borrow
    logic is_sub;
    assign is_sub = (alu_cmd.op == OP_SUB);

    // lane arithmetic, no carry crosses a lane; no flags leave the block
    always_comb begin
        lane_out = '0;
        case (alu_cmd.op)
            OP_ADD, OP_SUB: begin
                case (alu_cmd.size)
                    LANE_BYTE: begin
                        for (int i = 0; i < 8; i++) begin
                            lane_out[i*8 +: 8] = 8'(lane_op({8'h00, opa[i*8 +: 8]}, {8'h00, opb[i*8 +: 8]},
                                                            is_sub, 1'b1, alu_cmd.mode));
                        end
                    end
                    LANE_WORD: begin
                        for (int i = 0; i < 4; i++) begin
                            lane_out[i*16 +: 16] = lane_op(opa[i*16 +: 16], opb[i*16 +: 16],
                                                           is_sub, 1'b0, alu_cmd.mode);
                        end
                    end
                    default: begin
                        // doublewords wrap only; saturation is not defined for them
                        for (int i = 0; i < 2; i++) begin
                            lane_out[i*32 +: 32] = is_sub ? opa[i*32 +: 32] - opb[i*32 +: 32]
                                                          : opa[i*32 +: 32] + opb[i*32 +: 32];
                        end
                    end
                endcase
            end
            OP_AND:  lane_out = opa & opb;
            OP_ANDN: lane_out = ~opa & opb;
            OP_OR:   lane_out = opa | opb;
            OP_XOR:  lane_out = opa ^ opb;
            OP_MOV:  lane_out = opb;
            default: lane_out = '0;
        endcase
    end

    // storage update: alu result, then vector view, then fp view wins last
    always_ff @(posedge sys_clk) begin
        if (alu_cmd.valid) begin
            stack_mem[alu_cmd.dst] <= lane_out;
        end
        if (vec_wr.valid) begin
            stack_mem[vec_wr.idx] <= vec_wr.half ? {32'h0000_0000, vec_wr.data[31:0]} : vec_wr.data;
        end
        if (fp_wr.valid) begin
            stack_mem[fp_wr.idx] <= fp_wr.data;
        end
    end

    // result holds until the next request; done echoes the request for one cycle
    always_comb begin
        result_next = alu_cmd.valid ? lane_out : result_reg;
        done_next   = alu_cmd.valid;
    end

    // result register; storage stays unreset, so it must be written before it is read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_reg <= '0;
            done_reg   <= 1'b0;
        end else begin
            result_reg <= result_next;
            done_reg   <= done_next;
        end
    end

    // combinational same-cycle reads, bit 0 is the lowest memory byte
    always_comb begin
        vec_rd_data = vec_rd_half ? {32'h0000_0000, stack_mem[vec_rd_idx][31:0]} : stack_mem[vec_rd_idx];
        fp_rd_data  = stack_mem[fp_rd_idx];
    end
    assign alu_result = result_reg;
    assign alu_done   = done_reg;

    // request and answer timing
    a_done_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_cmd.valid |=> alu_done) else $error("done missing");
    a_idle_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !alu_cmd.valid |=> !alu_done) else $error("spurious done");

    // storage shared by both views; same-index clashes are left out on purpose
    a_views_alias: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fp_wr.valid && !vec_wr.valid && !alu_cmd.valid) ##1 (vec_rd_idx == $past(fp_wr.idx) && !vec_rd_half)
        |-> vec_rd_data == $past(fp_wr.data)) else $error("views differ");
    a_fp_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fp_wr.valid |=> stack_mem[$past(fp_wr.idx)] == $past(fp_wr.data))
        else $error("fp write lost");
    a_dst_written: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && !(vec_wr.valid && vec_wr.idx == alu_cmd.dst)
         && !(fp_wr.valid && fp_wr.idx == alu_cmd.dst)) |=> stack_mem[$past(alu_cmd.dst)] == alu_result)
        else $error("result not stored");
    a_half_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (vec_wr.valid && vec_wr.half && !(fp_wr.valid && fp_wr.idx == vec_wr.idx))
        |=> stack_mem[$past(vec_wr.idx)] == {32'h0000_0000, $past(vec_wr.data[31:0])})
        else $error("half write");
    a_half_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        vec_rd_half |-> vec_rd_data[63:32] == 32'h0000_0000) else $error("half read upper");

    // lane arithmetic at the saturation limits and at the wrap point
    a_ssat_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_ADD && alu_cmd.size == LANE_WORD && alu_cmd.mode == ARITH_SSAT
         && opa[63:48] == 16'h7fff && opb[63:48] == 16'h0001) |=> alu_result[63:48] == 16'h7fff)
        else $error("signed sat word");
    a_ssat_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_ADD && alu_cmd.size == LANE_BYTE && alu_cmd.mode == ARITH_SSAT
         && opa[7:0] == 8'h80 && opb[7:0] == 8'hff) |=> alu_result[7:0] == 8'h80)
        else $error("signed sat byte");
    a_usat_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_SUB && alu_cmd.size == LANE_BYTE && alu_cmd.mode == ARITH_USAT
         && opa[7:0] < opb[7:0]) |=> alu_result[7:0] == 8'h00) else $error("unsigned sat byte");
    a_usat_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_ADD && alu_cmd.size == LANE_WORD && alu_cmd.mode == ARITH_USAT
         && 17'(opa[15:0]) + 17'(opb[15:0]) > 17'h0ffff) |=> alu_result[15:0] == 16'hffff)
        else $error("unsigned sat word");
    a_wrap_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_ADD && alu_cmd.size == LANE_BYTE && alu_cmd.mode == ARITH_WRAP)
        |=> alu_result[15:8] == 8'($past(opa[15:8]) + $past(opb[15:8]))) else $error("wrap byte");
    a_dword_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_SUB && alu_cmd.size == LANE_DWORD)
        |=> alu_result[31:0] == $past(opa[31:0]) - $past(opb[31:0])) else $error("dword wrap");

    // logical and move operations take the full width
    a_xor_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_XOR) |=> alu_result == ($past(opa) ^ $past(opb)))
        else $error("xor width");
    a_and_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_AND) |=> alu_result == ($past(opa) & $past(opb)))
        else $error("and width");
    a_andn_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_ANDN) |=> alu_result == (~$past(opa) & $past(opb)))
        else $error("and-not width");
    a_or_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_OR) |=> alu_result == ($past(opa) | $past(opb)))
        else $error("or width");
    a_mov_src: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (alu_cmd.valid && alu_cmd.op == OP_MOV) |=> alu_result == $past(opb)) else $error("move width");

    // main scenarios the bench should reach
    c_ssat: cover property (@(posedge sys_clk) alu_cmd.valid && alu_cmd.mode == ARITH_SSAT);
    c_usat: cover property (@(posedge sys_clk) alu_cmd.valid && alu_cmd.mode == ARITH_USAT);
    c_half: cover property (@(posedge sys_clk) vec_wr.valid && vec_wr.half);
    c_wrap: cover property (@(posedge sys_clk) alu_cmd.valid && alu_cmd.mode == ARITH_WRAP);
    c_fp_write: cover property (@(posedge sys_clk) fp_wr.valid);
endmodule // simd_datapath

// ### bench/decode_model.sv
// stand-in for decode and load/store: it only issues requests, never reads back
module decode_model import simd_pkg::*; (
    input  wire logic sys_clk, // core clock
    output alu_cmd_s   alu_cmd, // operation request
    output reg_write_s vec_wr,  // vector view write
    output reg_write_s fp_wr    // fp stack view write
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until the bench asks for something
    initial begin
        alu_cmd = '0;
        vec_wr  = '0;
        fp_wr   = '0;
    end

    // one write held across one sampling edge; the data comes from general
    // registers or memory, a vector register never forms an address
    task automatic wr(input logic fp, input logic half, input logic [2:0] idx, input logic [63:0] d);
        @(posedge sys_clk);
        #1;
        if (fp) fp_wr = '{1'b1, half, idx, d};
        else vec_wr = '{1'b1, half, idx, d};
        @(posedge sys_clk);
        #1;
        fp_wr = '{1'b0, 1'b0, ~idx, ~d}; // released bus shows no stale value
        vec_wr = '{1'b0, 1'b0, ~idx, ~d};
    endtask

    // sources fixed at index 0 and 1, destination at index 2
    task automatic op(input alu_op_e o, input lane_size_e s, input arith_mode_e m);
        @(posedge sys_clk);
        #1;
        alu_cmd = '{1'b1, o, s, m, 3'h0, 3'h1, 3'h2};
        @(posedge sys_clk);
        #1;
        alu_cmd.valid = 1'b0;
    endtask
endmodule // decode_model

// ### bench/tb.sv
module tb import simd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] pat_a = 64'hf0f0_f0f0_0f0f_0f0f;
    localparam logic [63:0] pat_b = 64'hff00_ff00_ff00_ff00;
    logic sys_clk = 0, sys_rst = 1, vec_rd_half = 0;
    logic [2:0] vec_rd_idx = 0, fp_rd_idx = 0;
    logic [63:0] vec_rd_data, fp_rd_data, alu_result;
    logic alu_done;
    alu_cmd_s alu_cmd;
    reg_write_s vec_wr, fp_wr;
    int num_errors = 0, n_tests = 0, cycles = 0;

    always #5 sys_clk = ~sys_clk;

    decode_model i_dec (.sys_clk(sys_clk), .alu_cmd(alu_cmd), .vec_wr(vec_wr), .fp_wr(fp_wr));
    simd_datapath i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .alu_cmd(alu_cmd), .vec_wr(vec_wr),
        .fp_wr(fp_wr), .vec_rd_idx(vec_rd_idx), .vec_rd_half(vec_rd_half), .fp_rd_idx(fp_rd_idx),
        .vec_rd_data(vec_rd_data), .fp_rd_data(fp_rd_data), .alu_result(alu_result), .alu_done(alu_done));

    task close_out;
        $display("mismatches %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // read indices change just after an edge and stand across the next one
    task automatic rd(input logic [2:0] v, input logic [2:0] f, input logic h);
        @(posedge sys_clk);
        #1;
        vec_rd_idx = v;
        fp_rd_idx = f;
        vec_rd_half = h;
        #1;
    endtask

    // write every entry, read both views; then byte order and the 32-bit path
    task t_regs;
        for (int i = 0; i < 8; i++) i_dec.wr(1'b0, 1'b0, i[2:0], 64'h0706050403020100 + i);
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], i[2:0], 1'b0);
            chk(vec_rd_data, 64'h0706050403020100 + i);
            chk(fp_rd_data, 64'h0706050403020100 + i);
        end
        rd(3'h1, 3'h1, 1'b0);
        for (int b = 1; b < 8; b++) chk({56'h0, vec_rd_data[8*b+:8]}, 64'(b));
        i_dec.wr(1'b0, 1'b1, 3'h3, 64'hdead_beef_1234_5678);
        rd(3'h3, 3'h3, 1'b0);
        chk(vec_rd_data, 64'h0000_0000_1234_5678);
        i_dec.wr(1'b1, 1'b0, 3'h3, 64'hdead_beef_1234_5678);
        chk(vec_rd_data, 64'hdead_beef_1234_5678);
        rd(3'h3, 3'h3, 1'b1);
        chk(vec_rd_data, 64'h0000_0000_1234_5678);
        chk(fp_rd_data, 64'hdead_beef_1234_5678);
        rd(3'h3, 3'h2, 1'b0);
    endtask

    // one operand through each view, result seen on the port and in the fp view
    task automatic run_op(input alu_op_e o, input lane_size_e s, input arith_mode_e m,
                          input logic [63:0] a, input logic [63:0] b, input logic [63:0] e);
        i_dec.wr(1'b0, 1'b0, 3'h0, a);
        i_dec.wr(1'b1, 1'b0, 3'h1, b);
        i_dec.op(o, s, m);
        chk(alu_result, e);
        chk({63'h0, alu_done}, 64'h1);
        fp_rd_idx = 3'h2;
        #1;
        chk(fp_rd_data, e);
        @(posedge sys_clk);
        #1;
        chk({63'h0, alu_done}, 64'h0);
    endtask

    task t_ops;
        run_op(OP_ADD, LANE_WORD, ARITH_SSAT, 64'h7fff_8000_0001_1234, 64'h0001_ffff_0001_0001,
               64'h7fff_8000_0002_1235);
        run_op(OP_SUB, LANE_BYTE, ARITH_SSAT, 64'h807f_0500_0000_0000, 64'h01ff_0300_0000_0000,
               64'h807f_0200_0000_0000);
        run_op(OP_ADD, LANE_BYTE, ARITH_USAT, 64'hff80_0000_0000_0001, 64'h0180_0000_0000_0001,
               64'hffff_0000_0000_0002);
        run_op(OP_SUB, LANE_WORD, ARITH_USAT, 64'h0000_0005_0000_0000, 64'h0001_0003_0000_0000,
               64'h0000_0002_0000_0000);
        run_op(OP_ADD, LANE_BYTE, ARITH_WRAP, 64'h10ff, 64'h0001, 64'h1000);
        run_op(OP_ADD, LANE_WORD, ARITH_WRAP, 64'h7fff, 64'h0001, 64'h8000);
        run_op(OP_SUB, LANE_DWORD, ARITH_SSAT, 64'h8000_0000, 64'h0001, 64'h7fff_ffff);
        run_op(OP_AND, LANE_QWORD, ARITH_WRAP, pat_a, pat_b, 64'hf000_f000_0f00_0f00);
        run_op(OP_ANDN, LANE_BYTE, ARITH_WRAP, pat_a, pat_b, 64'h0f00_0f00_f000_f000);
        run_op(OP_OR, LANE_WORD, ARITH_SSAT, pat_a, pat_b, 64'hfff0_fff0_ff0f_ff0f);
        run_op(OP_XOR, LANE_DWORD, ARITH_USAT, pat_a, pat_b, 64'h0ff0_0ff0_f00f_f00f);
        run_op(OP_MOV, LANE_QWORD, ARITH_WRAP, pat_a, pat_b, pat_b);
        run_op(OP_SUB, LANE_BYTE, ARITH_USAT, 64'hfe03, 64'h0105, 64'hfd00);
        run_op(OP_ADD, LANE_WORD, ARITH_USAT, 64'h0001_ffff, 64'h0001_0001, 64'h0002_ffff);
        run_op(OP_SUB, LANE_WORD, ARITH_SSAT, 64'h8000_7fff_0000_0000, 64'h0001_ffff_0000_0000,
               64'h8000_7fff_0000_0000);
        run_op(OP_ADD, LANE_BYTE, ARITH_SSAT, 64'h7f80, 64'h01ff, 64'h7f80);
        run_op(OP_SUB, LANE_BYTE, ARITH_WRAP, 64'h0100, 64'h0001, 64'h01ff);
    endtask

    // hang guard, well above the roughly 155 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_regs();
        t_ops();
        close_out();
    end
endmodule // tb
